// >>> rtl/bulk_list_pointer_regs_map.vh
// register offsets, field positions and reset values of the list pointer bank
//
// Summary of operation
// - bulk head pointer at 28h, address in bits 31..4, resets to zero
// - bulk traversal starts at the descriptor named by the bulk head pointer
// - bulk head pointer is loaded from the shared memory area during initialization
// - bulk current pointer at 2Ch, address in bits 31..4, low bits reserved
// - bulk descriptors are served round-robin in insertion order
// - after serving a descriptor the current pointer moves to the next one
// - each frame resumes bulk processing where the previous frame stopped
// - at list end with filled flag set, copy head to current, clear flag; a same-cycle descriptor completion moves to the next one, flag kept
// - at list end with filled flag clear, keep the flag; the pointer moves only on a same-cycle descriptor completion
// - reads of the current pointer return its live value while enabled
// - current pointer starts at zero; zero marks the end of the list
// - control current pointer: same end-of-list reload and flag clear, starts at zero
`ifndef BULK_LIST_POINTER_REGS_MAP_VH
`define BULK_LIST_POINTER_REGS_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define OFS_CONTROL_REG       8'h04
`define OFS_COMMAND_STATUS    8'h08
`define OFS_CTRL_HEAD         8'h20
`define OFS_CTRL_CURRENT      8'h24
`define OFS_BULK_HEAD         8'h28
`define OFS_BULK_CURRENT      8'h2c

// ****************************************
// field positions
// ****************************************
`define BIT_CTRL_LIST_ENABLE  4
`define BIT_BULK_LIST_ENABLE  5
`define BIT_CTRL_FILLED       0
`define BIT_BULK_FILLED       1
`define PTR_LSB               4

// ****************************************
// reset values
// ****************************************
`define RST_POINTER           28'h000_0000
`define RST_WORD              32'h0000_0000

`endif

// >>> rtl/bulk_list_pointer_regs.v
// bulk and control list pointer registers with end-of-list reload logic
`timescale 1ns/1ps
`include "bulk_list_pointer_regs_map.vh"

module bulk_list_pointer_regs (
    input  wire        mclk,
    input  wire        rst_n,
    // register port
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    output reg  [31:0] reg_rdata_r,
    output reg         reg_rvalid_r,
    // list-processing engine
    input  wire        hcca_load,
    input  wire [31:0] hcca_bulk_head,
    input  wire [31:0] hcca_ctrl_head,
    input  wire        frame_start,
    input  wire        bulk_ed_done,
    input  wire [31:0] bulk_next_ed,
    input  wire        bulk_end_of_list,
    input  wire        ctrl_ed_done,
    input  wire [31:0] ctrl_next_ed,
    input  wire        ctrl_end_of_list,
    output reg  [31:0] bulk_fetch_addr_r,
    output reg         bulk_fetch_valid_r,
    output reg  [31:0] ctrl_fetch_addr_r,
    output reg         ctrl_fetch_valid_r,
    output reg         bulk_list_enable_r,
    output reg         ctrl_list_enable_r,
    output reg         list_filled_flag_r,
    output reg         ctrl_filled_flag_r
);

    // ****************************************
    // reset release
    // ****************************************
    reg         rst_meta_r;
    reg         rst_sync_r;

    // async assert, two-flop synchronous release, so every flop
    // below leaves reset on the same clock edge
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    // pointer field as a 16-byte aligned word, low bits forced to zero
    function [31:0] ptr_word;
        input [27:0] p;
        begin
            ptr_word = {p, 4'h0};
        end
    endfunction

    // address field of a bus word; the reserved low bits are dropped
    // here, so no register below can ever hold them
    function [27:0] ptr_field;
        input [31:0] w;
        begin
            ptr_field = w[31:`PTR_LSB];
        end
    endfunction

    // write strobe aimed at one register offset
    function wr_hit;
        input       wr;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_hit = wr && (addr == ofs);
        end
    endfunction

    // filled flag next value; the engine clears it only when it really
    // reloads at list end, so a descriptor completion in the same cycle
    // leaves it alone; a software set beats the clear so no work is lost
    function flag_next;
        input flag;
        input eol;
        input done;
        input set;
        begin
            flag_next = flag;
            if (eol && !done && flag)
                flag_next = 1'b0;
            if (set)
                flag_next = 1'b1;
        end
    endfunction

    // current pointer next value, shared by both lists; priority is
    // descriptor completion, then end of list, then a software write,
    // because a write racing the engine would lose the engine's place
    function [27:0] current_next;
        input [27:0] cur;
        input [27:0] head;
        input        flag;
        input        done;
        input [31:0] next_ed;
        input        eol;
        input        wr;
        input [31:0] wdata;
        begin
            current_next = cur;
            if (done)
                current_next = ptr_field(next_ed);
            else if (eol) begin
                if (flag)
                    current_next = head;
                else
                    current_next = cur;
            end else if (wr)
                current_next = ptr_field(wdata);
        end
    endfunction

    // a list may be fetched only while enabled and not at its end
    function fetch_ok;
        input        enable;
        input [27:0] cur;
        begin
            fetch_ok = enable && (cur != `RST_POINTER);
        end
    endfunction

    // ****************************************
    // state and next values
    // ****************************************
    reg  [27:0] bulk_head_addr_r;
    reg  [27:0] bulk_head_addr_nxt;
    reg  [27:0] bulk_current_addr_r;
    reg  [27:0] bulk_current_addr_nxt;
    reg  [27:0] ctrl_head_addr_r;
    reg  [27:0] ctrl_head_addr_nxt;
    reg  [27:0] ctrl_current_addr_r;
    reg  [27:0] ctrl_current_addr_nxt;
    reg         list_filled_flag_nxt;
    reg         ctrl_filled_flag_nxt;
    reg         bulk_list_enable_nxt;
    reg         ctrl_list_enable_nxt;
    reg  [31:0] rdata_nxt;

    // one decoded write strobe per register; unmapped offsets
    // decode to nothing, so such writes are simply ignored
    wire wr_ctl   = wr_hit(reg_wr, reg_addr, `OFS_CONTROL_REG);
    wire wr_cmd   = wr_hit(reg_wr, reg_addr, `OFS_COMMAND_STATUS);
    wire wr_chead = wr_hit(reg_wr, reg_addr, `OFS_CTRL_HEAD);
    wire wr_ccur  = wr_hit(reg_wr, reg_addr, `OFS_CTRL_CURRENT);
    wire wr_bhead = wr_hit(reg_wr, reg_addr, `OFS_BULK_HEAD);
    wire wr_bcur  = wr_hit(reg_wr, reg_addr, `OFS_BULK_CURRENT);

    // ****************************************
    // control and command status bits
    // ****************************************
    // filled flags: software writes one to set, engine clears at list end;
    // writing zero has no effect, so software cannot cancel pending work
    always @* begin
        bulk_list_enable_nxt = bulk_list_enable_r;
        ctrl_list_enable_nxt = ctrl_list_enable_r;
        if (wr_ctl) begin
            bulk_list_enable_nxt = reg_wdata[`BIT_BULK_LIST_ENABLE];
            ctrl_list_enable_nxt = reg_wdata[`BIT_CTRL_LIST_ENABLE];
        end
        list_filled_flag_nxt = flag_next(list_filled_flag_r, bulk_end_of_list, bulk_ed_done,
                                         wr_cmd && reg_wdata[`BIT_BULK_FILLED]);
        ctrl_filled_flag_nxt = flag_next(ctrl_filled_flag_r, ctrl_end_of_list, ctrl_ed_done,
                                         wr_cmd && reg_wdata[`BIT_CTRL_FILLED]);
    end

    // ****************************************
    // head pointers
    // ****************************************
    // init load from the shared area, otherwise software writes;
    // reserved low bits are never stored
    always @* begin
        bulk_head_addr_nxt = bulk_head_addr_r;
        ctrl_head_addr_nxt = ctrl_head_addr_r;
        if (hcca_load) begin
            bulk_head_addr_nxt = ptr_field(hcca_bulk_head);
            ctrl_head_addr_nxt = ptr_field(hcca_ctrl_head);
        end else begin
            if (wr_bhead)
                bulk_head_addr_nxt = ptr_field(reg_wdata);
            if (wr_chead)
                ctrl_head_addr_nxt = ptr_field(reg_wdata);
        end
    end

    // ****************************************
    // current pointers
    // ****************************************
    // engine updates take priority over software; software is expected to
    // write only while the list is disabled, so the clash is rare
    always @* begin
        bulk_current_addr_nxt = current_next(bulk_current_addr_r, bulk_head_addr_r, list_filled_flag_r,
                                             bulk_ed_done, bulk_next_ed, bulk_end_of_list,
                                             wr_bcur, reg_wdata);
        ctrl_current_addr_nxt = current_next(ctrl_current_addr_r, ctrl_head_addr_r, ctrl_filled_flag_r,
                                             ctrl_ed_done, ctrl_next_ed, ctrl_end_of_list,
                                             wr_ccur, reg_wdata);
    end

    // ****************************************
    // read mux
    // ****************************************
    // current pointers read live, not a snapshot; unmapped offsets
    // read as zero so a probing driver finds nothing behind them
    always @* begin
        case (reg_addr)
            `OFS_CONTROL_REG: begin
                rdata_nxt = `RST_WORD;
                rdata_nxt[`BIT_BULK_LIST_ENABLE] = bulk_list_enable_r;
                rdata_nxt[`BIT_CTRL_LIST_ENABLE] = ctrl_list_enable_r;
            end
            `OFS_COMMAND_STATUS: begin
                rdata_nxt = `RST_WORD;
                rdata_nxt[`BIT_BULK_FILLED] = list_filled_flag_r;
                rdata_nxt[`BIT_CTRL_FILLED] = ctrl_filled_flag_r;
            end
            `OFS_CTRL_HEAD:    rdata_nxt = ptr_word(ctrl_head_addr_r);
            `OFS_CTRL_CURRENT: rdata_nxt = ptr_word(ctrl_current_addr_r);
            `OFS_BULK_HEAD:    rdata_nxt = ptr_word(bulk_head_addr_r);
            `OFS_BULK_CURRENT: rdata_nxt = ptr_word(bulk_current_addr_r);
            default:           rdata_nxt = `RST_WORD;
        endcase
    end

    // ****************************************
    // pointer registers
    // ****************************************
    // all pointers clear on reset; zero current pointers mean end of list
    always @(posedge mclk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            bulk_head_addr_r    <= `RST_POINTER;
            bulk_current_addr_r <= `RST_POINTER;
            ctrl_head_addr_r    <= `RST_POINTER;
            ctrl_current_addr_r <= `RST_POINTER;
        end else begin
            bulk_head_addr_r    <= bulk_head_addr_nxt;
            bulk_current_addr_r <= bulk_current_addr_nxt;
            ctrl_head_addr_r    <= ctrl_head_addr_nxt;
            ctrl_current_addr_r <= ctrl_current_addr_nxt;
        end
    end

    // ****************************************
    // enable and filled flag registers
    // ****************************************
    // lists come out of reset disabled and with no pending work
    always @(posedge mclk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            list_filled_flag_r  <= 1'b0;
            ctrl_filled_flag_r  <= 1'b0;
            bulk_list_enable_r  <= 1'b0;
            ctrl_list_enable_r  <= 1'b0;
        end else begin
            list_filled_flag_r  <= list_filled_flag_nxt;
            ctrl_filled_flag_r  <= ctrl_filled_flag_nxt;
            bulk_list_enable_r  <= bulk_list_enable_nxt;
            ctrl_list_enable_r  <= ctrl_list_enable_nxt;
        end
    end

    // ****************************************
    // read answer
    // ****************************************
    // read data holds between reads, so a slow master may pick it up late;
    // the valid pulse alone marks a fresh answer
    always @(posedge mclk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            reg_rdata_r         <= `RST_WORD;
            reg_rvalid_r        <= 1'b0;
        end else begin
            reg_rvalid_r        <= reg_rd;
            if (reg_rd)
                reg_rdata_r     <= rdata_nxt;
        end
    end

    // ****************************************
    // fetch outputs
    // ****************************************
    // fetch address follows the current pointer across frames, so a new
    // frame resumes where the last one stopped; it is built from the next
    // value so the engine sees a new pointer without an extra cycle
    always @(posedge mclk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            bulk_fetch_addr_r   <= `RST_WORD;
            bulk_fetch_valid_r  <= 1'b0;
            ctrl_fetch_addr_r   <= `RST_WORD;
            ctrl_fetch_valid_r  <= 1'b0;
        end else begin
            bulk_fetch_addr_r   <= ptr_word(bulk_current_addr_nxt);
            bulk_fetch_valid_r  <= fetch_ok(bulk_list_enable_nxt, bulk_current_addr_nxt);
            ctrl_fetch_addr_r   <= ptr_word(ctrl_current_addr_nxt);
            ctrl_fetch_valid_r  <= fetch_ok(ctrl_list_enable_nxt, ctrl_current_addr_nxt);
        end
    end

endmodule // bulk_list_pointer_regs

// >>> tb/list_ptr_monitor.sv
// checker for the list pointer bank, bound to its ports
`timescale 1ns/1ps
module list_ptr_monitor (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_rdata_r,
    input wire logic        reg_rvalid_r,
    input wire logic        frame_start,
    input wire logic        bulk_ed_done,
    input wire logic [31:0] bulk_next_ed,
    input wire logic        bulk_end_of_list,
    input wire logic [31:0] bulk_fetch_addr_r,
    input wire logic        bulk_fetch_valid_r,
    input wire logic        bulk_list_enable_r,
    input wire logic        list_filled_flag_r,
    input wire logic [31:0] ctrl_fetch_addr_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_rd_answer; 1 |=> reg_rvalid_r == $past(reg_rd); endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer missing or spurious");
    property p_ptr_low; reg_rvalid_r && ($past(reg_addr) == 8'h28 || $past(reg_addr) == 8'h2c)
        |-> reg_rdata_r[3:0] == 4'h0; endproperty
    a_ptr_low: assert property (p_ptr_low) else $error("pointer low bits not zero");
    property p_served; bulk_ed_done |=> bulk_fetch_addr_r == ($past(bulk_next_ed) & 32'hffff_fff0); endproperty
    a_served: assert property (p_served) else $error("current pointer did not advance");
    property p_eol_idle; bulk_end_of_list && !list_filled_flag_r && !bulk_ed_done && !reg_wr
        |=> $stable(bulk_fetch_addr_r) && !list_filled_flag_r; endproperty
    a_eol_idle: assert property (p_eol_idle) else $error("end of list changed state with flag clear");
    property p_eol_reload; bulk_end_of_list && list_filled_flag_r && !bulk_ed_done && !reg_wr
        |=> !list_filled_flag_r; endproperty
    a_eol_reload: assert property (p_eol_reload) else $error("filled flag not cleared at list end");
    property p_frame; frame_start && !bulk_ed_done && !bulk_end_of_list && !reg_wr
        |=> $stable(bulk_fetch_addr_r); endproperty
    a_frame: assert property (p_frame) else $error("frame start moved the current pointer");
    property p_fetch_valid; bulk_fetch_valid_r == (bulk_list_enable_r && bulk_fetch_addr_r != 32'h0); endproperty
    a_fetch_valid: assert property (p_fetch_valid) else $error("fetch valid wrong");
    property p_align; bulk_fetch_addr_r[3:0] == 4'h0 && ctrl_fetch_addr_r[3:0] == 4'h0; endproperty
    a_align: assert property (p_align) else $error("fetch address not 16-byte aligned");
endmodule // list_ptr_monitor

bind bulk_list_pointer_regs list_ptr_monitor mon (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .frame_start(frame_start),
    .bulk_ed_done(bulk_ed_done), .bulk_next_ed(bulk_next_ed), .bulk_end_of_list(bulk_end_of_list),
    .bulk_fetch_addr_r(bulk_fetch_addr_r), .bulk_fetch_valid_r(bulk_fetch_valid_r),
    .bulk_list_enable_r(bulk_list_enable_r), .list_filled_flag_r(list_filled_flag_r),
    .ctrl_fetch_addr_r(ctrl_fetch_addr_r));

// >>> tb/host_driver_model.sv
// host driver model: register reads and writes over the strobe port
`timescale 1ns/1ps
module host_driver_model (
    input  wire        mclk,
    input  wire [31:0] reg_rdata_r,
    input  wire        reg_rvalid_r,
    output reg         reg_wr,
    output reg         reg_rd,
    output reg  [7:0]  reg_addr,
    output reg  [31:0] reg_wdata
);
    reg enable_r; // software's own copy of bulk list enable
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, enable_r} = '0;
    end
    // released lines show inverted data so stale values never pass
    task write_reg(input [7:0] a, input [31:0] d);
        if (!(a == 8'h2c && enable_r)) begin
            @(posedge mclk);
            #1 reg_wr = 1'b1;
            reg_addr = a;
            reg_wdata = (a == 8'h28 || a == 8'h2c) ? (d & 32'hffff_fff0) : d;
            @(posedge mclk);
            #1 reg_wr = 1'b0;
            reg_addr = ~a;
            reg_wdata = ~reg_wdata;
            if (a == 8'h04) enable_r = d[5];
        end
    endtask
    task read_reg(input [7:0] a, output [31:0] d, output v);
        @(posedge mclk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge mclk);
        #1 reg_rd = 1'b0;
        reg_addr = ~a;
        v = reg_rvalid_r;
        d = reg_rdata_r;
    endtask
endmodule // host_driver_model

// >>> tb/testbench.sv
// self-checking testbench for the list pointer bank
`timescale 1ns/1ps
module testbench;
    reg         mclk;
    reg         rst_n;
    reg  [5:0]  ev;      // load, frame, done, end, ctrl done, ctrl end
    reg  [31:0] next_ed;
    reg  [31:0] rd;
    reg         rv;
    integer     fail_count;
    integer     n_checks;
    wire        reg_wr, reg_rd, reg_rvalid_r, bulk_fetch_valid_r, list_filled_flag_r;
    wire [7:0]  reg_addr;
    wire [31:0] reg_wdata, reg_rdata_r, bulk_fetch_addr_r, ctrl_fetch_addr_r;
    wire        ctrl_fetch_valid_r, bulk_list_enable_r, ctrl_list_enable_r, ctrl_filled_flag_r;
    host_driver_model host (.mclk(mclk), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    bulk_list_pointer_regs DUT (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .hcca_load(ev[5]),
        .hcca_bulk_head(32'ha000_0010), .hcca_ctrl_head(32'h5000_0040), .frame_start(ev[4]),
        .bulk_ed_done(ev[3]), .bulk_next_ed(next_ed), .bulk_end_of_list(ev[2]), .ctrl_ed_done(ev[1]),
        .ctrl_next_ed(next_ed), .ctrl_end_of_list(ev[0]), .bulk_fetch_addr_r(bulk_fetch_addr_r),
        .bulk_fetch_valid_r(bulk_fetch_valid_r), .ctrl_fetch_addr_r(ctrl_fetch_addr_r),
        .ctrl_fetch_valid_r(ctrl_fetch_valid_r), .bulk_list_enable_r(bulk_list_enable_r),
        .ctrl_list_enable_r(ctrl_list_enable_r), .list_filled_flag_r(list_filled_flag_r),
        .ctrl_filled_flag_r(ctrl_filled_flag_r));
    task chk(input [31:0] got, input [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task rd_chk(input [7:0] a, input [31:0] exp);
        host.read_reg(a, rd, rv);
        chk({31'h0, rv}, 32'h1);
        chk(rd, exp);
    endtask
    // engine events last one cycle, one clock edge apart
    task pulse(input [5:0] e);
        @(posedge mclk);
        #1 ev = e;
        @(posedge mclk);
        #1 ev = 6'h0;
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // hang guard at 800 cycles, far beyond the roughly 70 cycles the tests take
    initial begin
        #20000;
        fail_count = fail_count + 1;
        test_done;
    end
    initial begin
        {rst_n, ev, next_ed, fail_count, n_checks} = '0;
        repeat (2) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        rd_chk(8'h28, 32'h0);
        rd_chk(8'h2c, 32'h0);
        rd_chk(8'h24, 32'h0);
        rd_chk(8'h3c, 32'h0);
        host.write_reg(8'h28, 32'h1234_5678);
        rd_chk(8'h28, 32'h1234_5670);
        pulse(6'h20);
        rd_chk(8'h28, 32'ha000_0010);
        host.write_reg(8'h2c, 32'h0000_0100);
        rd_chk(8'h2c, 32'h0000_0100);
        chk({31'h0, bulk_fetch_valid_r}, 32'h0);
        host.write_reg(8'h04, 32'h0000_0030);
        chk({31'h0, bulk_fetch_valid_r}, 32'h1);
        chk(bulk_fetch_addr_r, 32'h0000_0100);
        chk({30'h0, bulk_list_enable_r, ctrl_list_enable_r}, 32'h3);
        rd_chk(8'h04, 32'h0000_0030);
        next_ed = 32'h0000_0208;
        pulse(6'h08);
        rd_chk(8'h2c, 32'h0000_0200);
        pulse(6'h10);
        pulse(6'h04);
        rd_chk(8'h2c, 32'h0000_0200);
        chk({31'h0, list_filled_flag_r}, 32'h0);
        host.write_reg(8'h08, 32'h0000_0002);
        chk({31'h0, list_filled_flag_r}, 32'h1);
        rd_chk(8'h08, 32'h0000_0002);
        pulse(6'h04);
        chk(bulk_fetch_addr_r, 32'ha000_0010);
        chk({31'h0, list_filled_flag_r}, 32'h0);
        next_ed = 32'h0;
        pulse(6'h08);
        chk({31'h0, bulk_fetch_valid_r}, 32'h0);
        chk({31'h0, ctrl_fetch_valid_r}, 32'h0);
        host.write_reg(8'h08, 32'h0000_0001);
        chk({31'h0, ctrl_filled_flag_r}, 32'h1);
        pulse(6'h01);
        chk(ctrl_fetch_addr_r, 32'h5000_0040);
        chk({30'h0, ctrl_fetch_valid_r, ctrl_filled_flag_r}, 32'h2);
        rd_chk(8'h20, 32'h5000_0040);
        next_ed = 32'h0000_0300;
        pulse(6'h02);
        rd_chk(8'h24, 32'h0000_0300);
        host.write_reg(8'h08, 32'h0000_0002);
        next_ed = 32'h0000_0400;
        pulse(6'h0c);
        chk(bulk_fetch_addr_r, 32'h0000_0400);
        chk({31'h0, list_filled_flag_r}, 32'h1);
        host.write_reg(8'h04, 32'h0000_0010);
        chk({30'h0, bulk_list_enable_r, ctrl_list_enable_r}, 32'h1);
        next_ed = 32'h0000_0600;
        fork
            host.write_reg(8'h2c, 32'h0000_0500);
            pulse(6'h08);
        join
        rd_chk(8'h2c, 32'h0000_0600);
        test_done;
    end
endmodule // testbench
